// ==== nvd_pkg.sv ====
// ------------------------------------------------------------
// shared constants for the nonvolatile data access block
// ------------------------------------------------------------
package nvd_pkg;
  // array geometry
  localparam int NVD_DEPTH = 64;           // sixty-four byte locations
  localparam int NVD_AW = 6;               // array address width
  localparam int NVD_DW = 8;               // byte width
  // register placement (address and data answer in any bank, control in bank 1)
  localparam logic [7:0] NVD_ADDR_OFS = 8'h1e;
  localparam logic [7:0] NVD_DATA_OFS = 8'h1f;
  localparam logic [7:0] NVD_CTRL_OFS = 8'h40;
  localparam logic NVD_CTRL_BANK = 1'b1;
  // control register field positions
  localparam int NVD_WPERMIT_BIT = 3;
  localparam int NVD_WTRIG_BIT = 2;
  localparam int NVD_RPERMIT_BIT = 1;
  localparam int NVD_RTRIG_BIT = 0;
  // reset values
  localparam logic NVD_CTRL_RST = 1'b0;
  localparam logic [NVD_AW-1:0] NVD_ADDR_RST = 6'h00;
  localparam logic [NVD_DW-1:0] NVD_DATA_RST = 8'h00;
  localparam logic [NVD_DW-1:0] NVD_ZERO_BYTE = 8'h00;
  // cycle durations in system clocks (array timer stand-in)
  localparam int NVD_CNT_W = 16;
  localparam logic [NVD_CNT_W-1:0] NVD_RD_CYCLES_DEF = 16'h0004;
  localparam logic [NVD_CNT_W-1:0] NVD_WR_CYCLES_DEF = 16'h0200;
  localparam logic [NVD_CNT_W-1:0] NVD_CNT_ONE = 16'h0001;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    NVD_IDLE = 4'b0001,
    NVD_READ = 4'b0010,
    NVD_WRITE = 4'b0100,
    NVD_SETTLE = 4'b1000
  } nvd_state_t;
endpackage : nvd_pkg

// ==== nvd_ctrl.sv ====
// How it works
// - sixty-four byte array, not in data space
// - single-byte access via address, data, control
// - address and data reachable by direct addressing
// - control reachable only through bank-1 indirect port
// - address holds six bits, top two read zero
// - control bits seven to four read zero
// - write permit gates every write cycle
// - write trigger with permit starts write cycle
// - hardware clears write trigger at write end
// - write trigger without prior permit does nothing
// - read permit gates every read cycle
// - read trigger with permit starts read
// - hardware clears read trigger at read end
// - read trigger without prior permit does nothing
// - read byte stays in data register afterwards
// - write stores data byte; timer sets duration
// - write end sets done flag and request
`timescale 1ns/100ps
module nvd_ctrl
  import nvd_pkg::*;
#(
  parameter logic [NVD_CNT_W-1:0] RD_CYCLES = NVD_RD_CYCLES_DEF, // read duration in clocks
  parameter logic [NVD_CNT_W-1:0] WR_CYCLES = NVD_WR_CYCLES_DEF  // write duration in clocks
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_bank,
  input wire logic sfr_indirect,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic array_done_clr,
  output logic array_done_flag,
  output logic mf_req
);

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  logic addr_hit; // address register selected
  logic data_hit; // data register selected
  logic ctrl_hit; // control register selected
  // special registers answer in any bank, directly or through the pointer
  assign addr_hit = (sfr_addr == NVD_ADDR_OFS);
  assign data_hit = (sfr_addr == NVD_DATA_OFS);
  // the control register needs the bank-1 indirect path; a direct 40h never lands here
  assign ctrl_hit = sfr_indirect && (sfr_bank == NVD_CTRL_BANK) && (sfr_addr == NVD_CTRL_OFS);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [NVD_DW-1:0] mem [NVD_DEPTH]; // the byte array itself, no reset on purpose
  logic [NVD_AW-1:0] nv_address, next_nv_address; // array address
  logic [NVD_DW-1:0] nv_data, next_nv_data; // data register
  logic write_permit, next_write_permit; // control bit 3
  logic write_trig, next_write_trig; // control bit 2
  logic read_permit, next_read_permit; // control bit 1
  logic read_trig, next_read_trig; // control bit 0
  nvd_state_t state, next_state; // cycle sequencer
  logic [NVD_CNT_W-1:0] cnt, next_cnt; // array timer
  logic done_tgl, next_done_tgl; // array-side completion toggle
  logic done_s1, done_s2, done_s3; // completion synchroniser
  logic [NVD_DW-1:0] rd_byte, next_rd_byte; // byte fetched by the array
  logic [7:0] next_sfr_rdata; // read mux result
  logic next_flag; // done flag next value
  logic next_mf_req; // shared request pulse
  logic done_edge; // synchronised completion seen
  logic wr_end; // array write happens this cycle
  logic rd_end; // array fetch happens this cycle

  assign done_edge = done_s2 ^ done_s3;
  assign wr_end = (state == NVD_WRITE) && (cnt == NVD_CNT_ONE);
  assign rd_end = (state == NVD_READ) && (cnt == NVD_CNT_ONE);

  // ------------------------------------------------------------
  // next-value logic for registers and sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_nv_address = nv_address;
    next_nv_data = nv_data;
    next_write_permit = write_permit;
    next_write_trig = write_trig;
    next_read_permit = read_permit;
    next_read_trig = read_trig;
    next_state = state;
    next_cnt = cnt;
    next_done_tgl = done_tgl;
    next_rd_byte = rd_byte;
    next_flag = array_done_flag;
    next_mf_req = 1'b0;
    // software writes
    if (sfr_wr && addr_hit) begin
      next_nv_address = sfr_wdata[NVD_AW-1:0];
    end
    if (sfr_wr && data_hit) begin
      next_nv_data = sfr_wdata;
    end
    if (sfr_wr && ctrl_hit) begin
      next_write_permit = sfr_wdata[NVD_WPERMIT_BIT];
      next_read_permit = sfr_wdata[NVD_RPERMIT_BIT];
      // triggers only rise from idle and only on a permit already stored;
      // writing zero to a trigger is ignored since only hardware ends a cycle
      if (state == NVD_IDLE) begin
        if (sfr_wdata[NVD_WTRIG_BIT] && write_permit) begin
          next_write_trig = 1'b1;
          next_state = NVD_WRITE;
          next_cnt = WR_CYCLES;
        end else if (sfr_wdata[NVD_RTRIG_BIT] && read_permit) begin
          next_read_trig = 1'b1;
          next_state = NVD_READ;
          next_cnt = RD_CYCLES;
        end
      end
    end
    case (state)
      NVD_IDLE: begin
        // waiting for a trigger
      end
      NVD_READ, NVD_WRITE: begin
        // array timer runs on its own; the core clock merely counts for it
        next_cnt = cnt - NVD_CNT_ONE;
        if (cnt == NVD_CNT_ONE) begin
          next_done_tgl = ~done_tgl;
          next_state = NVD_SETTLE;
          if (rd_end) begin
            next_rd_byte = mem[nv_address];
          end
        end
      end
      NVD_SETTLE: begin
        // completion must cross into the core domain before triggers clear
        if (done_edge) begin
          next_state = NVD_IDLE;
          if (write_trig) begin
            next_write_trig = 1'b0;
            next_flag = 1'b1;
            next_mf_req = 1'b1;
          end
          if (read_trig) begin
            next_read_trig = 1'b0;
            next_nv_data = rd_byte;
          end
        end
      end
      default: begin
        next_state = NVD_IDLE;
      end
    endcase
    // software clear loses to a write completion in the same cycle
    if (array_done_clr && !(next_mf_req)) begin
      next_flag = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // read mux, registered answer
  // ------------------------------------------------------------
  always_comb begin
    next_sfr_rdata = sfr_rdata;
    if (sfr_rd) begin
      if (ctrl_hit) begin
        next_sfr_rdata = {4'h0, write_permit, write_trig, read_permit, read_trig};
      end else if (addr_hit) begin
        next_sfr_rdata = {2'h0, nv_address};
      end else if (data_hit) begin
        next_sfr_rdata = nv_data;
      end else begin
        next_sfr_rdata = NVD_ZERO_BYTE;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      nv_address <= NVD_ADDR_RST;
      nv_data <= NVD_DATA_RST;
      write_permit <= NVD_CTRL_RST;
      write_trig <= NVD_CTRL_RST;
      read_permit <= NVD_CTRL_RST;
      read_trig <= NVD_CTRL_RST;
      state <= NVD_IDLE;
      cnt <= '0;
      done_tgl <= 1'b0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      rd_byte <= NVD_ZERO_BYTE;
      sfr_rdata <= NVD_ZERO_BYTE;
      array_done_flag <= 1'b0;
      mf_req <= 1'b0;
    end else begin
      nv_address <= next_nv_address;
      nv_data <= next_nv_data;
      write_permit <= next_write_permit;
      write_trig <= next_write_trig;
      read_permit <= next_read_permit;
      read_trig <= next_read_trig;
      state <= next_state;
      cnt <= next_cnt;
      done_tgl <= next_done_tgl;
      done_s1 <= done_tgl; // first stage, read only by the second
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      rd_byte <= next_rd_byte;
      sfr_rdata <= next_sfr_rdata;
      array_done_flag <= next_flag;
      mf_req <= next_mf_req;
    end
  end

  // ------------------------------------------------------------
  // byte array write port
  // ------------------------------------------------------------
  // address and data are used live, so software must leave them alone mid-cycle
  always_ff @(posedge core_clk) begin
    if (wr_end) begin
      mem[nv_address] <= nv_data;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  ctrl_upper_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sfr_rd && ctrl_hit |=> sfr_rdata[7:4] == 4'h0) else $error("control upper bits not zero");
  addr_upper_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sfr_rd && addr_hit && !ctrl_hit |=> sfr_rdata[7:6] == 2'h0) else $error("address upper bits not zero");
  write_start_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sfr_wr && ctrl_hit && state == NVD_IDLE && write_permit && sfr_wdata[NVD_WTRIG_BIT]
    |=> write_trig && state == NVD_WRITE && cnt == WR_CYCLES)
    else $error("write cycle did not start with a full timer");
  // the timer can be far longer than a plain delay may reach, so its steps are checked one at a time
  write_run_a: assert property (@(posedge core_clk) disable iff (!rstn)
    state == NVD_WRITE && cnt != NVD_CNT_ONE |=> state == NVD_WRITE && cnt == $past(cnt) - NVD_CNT_ONE)
    else $error("write timer did not count down");
  write_end_a: assert property (@(posedge core_clk) disable iff (!rstn)
    state == NVD_WRITE && cnt == NVD_CNT_ONE |=> state == NVD_SETTLE)
    else $error("write cycle did not end on timer expiry");
  write_block_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sfr_wr && ctrl_hit && state == NVD_IDLE && !write_permit |=> !write_trig)
    else $error("write started without permit");
  read_block_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sfr_wr && ctrl_hit && state == NVD_IDLE && !read_permit |=> !read_trig)
    else $error("read started without permit");
  write_done_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(write_trig) |-> array_done_flag && mf_req) else $error("write end did not raise done");
  read_data_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(read_trig) |-> nv_data == rd_byte) else $error("read byte not in data register");
  direct_ctrl_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sfr_wr && !sfr_indirect |=> $stable({write_permit, read_permit}))
    else $error("direct access changed control");
  settle_bound_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(state == NVD_SETTLE) |-> ##[2:4] state == NVD_IDLE) else $error("completion sync too slow");
  one_trigger_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(write_trig && read_trig)) else $error("both triggers set");

endmodule : nvd_ctrl

// ==== nvd_cpu_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// processor core stand-in issuing register accesses
// ------------------------------------------------------------
module nvd_cpu_model (
  input wire logic core_clk,
  output logic [7:0] sfr_addr,
  output logic sfr_bank,
  output logic sfr_indirect,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  output logic array_done_clr
);
  // bus idle at time zero, nothing selected
  initial begin
    sfr_addr = 8'h00;
    sfr_bank = 1'b0;
    sfr_indirect = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    array_done_clr = 1'b0;
  end

  // one byte access; m is {bank, indirect}, read data lands one edge after the strobe
  task automatic acc(input logic [1:0] m, input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge core_clk);
    sfr_bank <= m[1];
    sfr_indirect <= m[0];
    sfr_addr <= a;
    sfr_wr <= w;
    sfr_rd <= !w;
    sfr_wdata <= d;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    // released data is scrambled so a stale byte never looks valid
    sfr_wdata <= ~d;
    @(posedge core_clk);
    #1 q = sfr_rdata;
  endtask : acc

  // permit first, trigger in a later write, one trigger at a time, then poll for the clear
  task automatic run(input logic wr, output logic ok);
    logic [7:0] p;
    logic [7:0] q;
    p = wr ? 8'h08 : 8'h02;
    ok = 1'b0;
    acc(2'b11, 8'h40, 1'b1, p, q);
    acc(2'b11, 8'h40, 1'b1, p | (p >> 1), q);
    for (int n = 0; n < 60 && !ok; n++) begin
      acc(2'b11, 8'h40, 1'b0, 8'h00, q);
      ok = (q === p);
    end
  endtask : run

  // one-cycle software clear of the done flag
  task automatic clr();
    @(posedge core_clk);
    array_done_clr <= 1'b1;
    @(posedge core_clk);
    array_done_clr <= 1'b0;
    #1;
  endtask : clr
endmodule : nvd_cpu_model

// ==== tb.sv ====
`timescale 1ns/100ps
module tb
  import nvd_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, q, d;
  logic sfr_bank, sfr_indirect, sfr_wr, sfr_rd, array_done_clr, array_done_flag, mf_req, ok;
  int failures = 0;
  int checked = 0;
  int pulses = 0;
  integer seed = 32'h83b39270;
  logic [7:0] mem [64];
  logic [5:0] a;
  logic [5:0] wa [8];

  always #5 core_clk = ~core_clk;
  // count request pulses; a level stuck high shows up as too many
  always @(posedge core_clk)
    if (mf_req === 1'b1) pulses <= pulses + 1;

  // short array timers keep the run brief
  nvd_ctrl #(.RD_CYCLES(16'h0002), .WR_CYCLES(16'h0008)) dut (.core_clk(core_clk), .rstn(rstn),
    .sfr_addr(sfr_addr), .sfr_bank(sfr_bank), .sfr_indirect(sfr_indirect), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .array_done_clr(array_done_clr),
    .array_done_flag(array_done_flag), .mf_req(mf_req));
  nvd_cpu_model cpu (.core_clk(core_clk), .sfr_addr(sfr_addr), .sfr_bank(sfr_bank),
    .sfr_indirect(sfr_indirect), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .array_done_clr(array_done_clr));

  // upper two address bits always read back as zero
  function automatic logic [7:0] addr_view(input logic [7:0] v);
    return {2'b00, v[5:0]};
  endfunction : addr_view

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    cpu.acc(2'b11, NVD_CTRL_OFS, 1'b0, 8'h00, q);
    chk("control", q, 8'h00);
    $display("test reset done");
    // direct registers with corner and random bytes
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
      cpu.acc(2'b00, NVD_ADDR_OFS, 1'b1, d, q);
      cpu.acc(2'b00, NVD_DATA_OFS, 1'b1, ~d, q);
      cpu.acc(2'b00, NVD_ADDR_OFS, 1'b0, 8'h00, q);
      chk("address", q, addr_view(d));
      cpu.acc(2'b00, NVD_DATA_OFS, 1'b0, 8'h00, q);
      chk("data", q, ~d);
    end
    $display("test direct done");
    // control unreachable directly or via bank 0; triggers without permit do nothing
    cpu.acc(2'b00, NVD_CTRL_OFS, 1'b1, 8'h0a, q);
    cpu.acc(2'b01, NVD_CTRL_OFS, 1'b1, 8'h0a, q);
    cpu.acc(2'b11, NVD_CTRL_OFS, 1'b1, 8'hf5, q);
    cpu.acc(2'b11, NVD_CTRL_OFS, 1'b0, 8'h00, q);
    chk("control", q, 8'h00);
    // a permit set then cleared blocks its trigger
    for (int i = 0; i < 2; i++) begin
      d = i ? 8'h02 : 8'h08;
      cpu.acc(2'b11, NVD_CTRL_OFS, 1'b1, d, q);
      cpu.acc(2'b00, NVD_CTRL_OFS, 1'b0, 8'h00, q);
      chk("direct control", q, NVD_ZERO_BYTE);
      cpu.acc(2'b11, NVD_CTRL_OFS, 1'b0, 8'h00, q);
      chk("control", q, d);
      cpu.acc(2'b11, NVD_CTRL_OFS, 1'b1, 8'h00, q);
      cpu.acc(2'b11, NVD_CTRL_OFS, 1'b1, d >> 1, q);
      repeat (20) @(posedge core_clk);
      cpu.acc(2'b11, NVD_CTRL_OFS, 1'b0, 8'h00, q);
      chk("control", q, 8'h00);
    end
    chk("requests", 8'(pulses), 8'h00);
    $display("test permits done");
    // write then read back, boundary addresses first
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
      d = 8'($random(seed));
      wa[i] = a;
      mem[a] = d;
      cpu.acc(2'b00, NVD_ADDR_OFS, 1'b1, {2'b00, a}, q);
      cpu.acc(2'b00, NVD_DATA_OFS, 1'b1, d, q);
      cpu.run(1'b1, ok);
      chk("write end", {7'h00, ok}, 8'h01);
      chk("done flag", {7'h00, array_done_flag}, 8'h01);
      chk("requests", 8'(pulses), 8'(i + 1));
      cpu.clr();
      chk("done flag", {7'h00, array_done_flag}, 8'h00);
      cpu.acc(2'b00, NVD_DATA_OFS, 1'b1, ~d, q);
      cpu.run(1'b0, ok);
      chk("read end", {7'h00, ok}, 8'h01);
      chk("done flag", {7'h00, array_done_flag}, 8'h00);
      cpu.acc(2'b00, NVD_DATA_OFS, 1'b0, 8'h00, q);
      chk("read byte", q, d);
    end
    $display("test write read done");
    // every written location keeps its last byte
    for (int i = 0; i < 8; i++) begin
      cpu.acc(2'b00, NVD_ADDR_OFS, 1'b1, {2'b00, wa[i]}, q);
      cpu.run(1'b0, ok);
      chk("read end", {7'h00, ok}, 8'h01);
      cpu.acc(2'b00, NVD_DATA_OFS, 1'b0, 8'h00, q);
      chk("array", q, mem[wa[i]]);
    end
    $display("test retention done");
    conclude();
  end

  // watchdog: the sequence needs well under ten thousand cycles
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule : tb
